// *** hw/sesr_status_core.sv ***
// status byte, event register sets and service request logic
//
// What this block does
// - power-up sets standard event bit 7
// - command errors set standard event bit 5
// - execution errors set standard event bit 4
// - lost response data sets bit 2
// - armed completion sets bit 0, independent of query
// - enabled standard events drive status bit 5
// - write/read event mask; read then clear events
// - processor link, calibration faults set bits 7,6
// - tuning idle, fresh reading set bits 5,4
// - loop one, two ramp done set bits 3,2
// - overrange, visible alarm set bits 1,0
// - operation mask, event and condition access commands
// - enabled operation events drive status bit 7
// - status bit 4 follows output message presence
// - summary bits follow sources without latching
// - master summary is OR of enabled summaries
// - master summary rising sets request and line
// - serial poll returns byte, clears request only
// - no repeat request until source cleared
// - master summary holds until summaries cleared/disabled
// - status query returns master summary, clears nothing
// - write and read the request enable mask
// - answers and masks carry binary weighted value
// - clear-status command empties both event registers
`timescale 1ns/1ps
`default_nettype none
module sesr_status_core (
  input  wire logic                    i_ref_clk,
  input  wire logic                    i_rst_n,
  input  wire sesr_pkg::sesr_cmd_s     i_cmd,
  input  wire sesr_pkg::sesr_std_evt_s i_std_evt,
  input  wire logic                    i_ops_idle,
  input  wire logic [7:0]              i_op_cond,
  input  wire logic                    i_msg_avail,
  output var  sesr_pkg::sesr_rsp_s     o_rsp,
  output logic                         o_srq
);

  sesr_pkg::sesr_main_st_s state_ff;
  sesr_pkg::sesr_main_st_s nxt_state;

  logic [7:0] std_q;
  logic [7:0] op_q;
  logic [7:0] std_set;
  logic       std_clear;
  logic       op_clear;
  logic       opc_fire;
  logic       osb;
  logic       esb;
  logic       mss;
  logic       mss_rise;
  logic [7:0] sb_sum;
  logic [7:0] stb_mss;
  logic [7:0] stb_poll;
  logic       cmd_v;
  logic       is_rd;
  logic [7:0] rd_value;

  // decimal digits of a byte, hundreds in the top nibble
  function automatic logic [11:0] to_bcd(input logic [7:0] v);
    logic [19:0] sh;
    sh = {12'h000, v};
    for (int i = 0; i < 8; i++)
    begin
      if (sh[11:8] >= 4'h5)
        sh[11:8] = sh[11:8] + 4'h3;
      if (sh[15:12] >= 4'h5)
        sh[15:12] = sh[15:12] + 4'h3;
      if (sh[19:16] >= 4'h5)
        sh[19:16] = sh[19:16] + 4'h3;
      sh = {sh[18:0], 1'b0};
    end
    return sh[19:8];
  endfunction : to_bcd

  assign cmd_v = i_cmd.valid;

  // completion only counts once the host has armed it with the command
  assign opc_fire = state_ff.opc_arm & i_ops_idle;

  always_comb
  begin
    std_set                    = 8'h00;
    std_set[sesr_pkg::STD_CME] = i_std_evt.cmd_error;
    std_set[sesr_pkg::STD_EXE] = i_std_evt.exec_error;
    std_set[sesr_pkg::STD_QYE] = i_std_evt.query_lost;
    std_set[sesr_pkg::STD_OPC] = opc_fire;
  end

  assign std_clear = cmd_v & ((i_cmd.code == sesr_pkg::CMD_ESR_RD) |
                              (i_cmd.code == sesr_pkg::CMD_CLS));
  assign op_clear  = cmd_v & ((i_cmd.code == sesr_pkg::CMD_OPR_RD) |
                              (i_cmd.code == sesr_pkg::CMD_CLS));

  // power-up is the reset release, so bit 7 is the reset value
  sesr_evt_reg #(
    .RESET_VAL (sesr_pkg::STD_RESET)
  ) u_std_evt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (std_set),
    .i_clear   (std_clear),
    .o_value   (std_q)
  );

  // conditions are levels: an event re-latches while its cause persists
  sesr_evt_reg #(
    .RESET_VAL (sesr_pkg::OP_RESET)
  ) u_op_evt (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_set     (i_op_cond),
    .i_clear   (op_clear),
    .o_value   (op_q)
  );

  // summaries are pure combinational views of the latched sources
  assign esb = |(std_q & state_ff.ese);
  assign osb = |(op_q & state_ff.ope);

  always_comb
  begin
    sb_sum                   = 8'h00;
    sb_sum[sesr_pkg::SB_OSB] = osb;
    sb_sum[sesr_pkg::SB_ESB] = esb;
    sb_sum[sesr_pkg::SB_MAV] = i_msg_avail;
  end

  assign mss      = |(sb_sum & state_ff.sre);
  // a summary that stays high after a poll gives no new edge
  assign mss_rise = mss & ~state_ff.mss_prev;

  always_comb
  begin
    stb_mss                    = sb_sum;
    stb_mss[sesr_pkg::SB_MSS]  = mss;
    stb_poll                   = sb_sum;
    stb_poll[sesr_pkg::SB_MSS] = state_ff.rqs;
  end

  always_comb
  begin
    is_rd    = 1'b0;
    rd_value = 8'h00;
    if (cmd_v)
    begin
      case (i_cmd.code)
        sesr_pkg::CMD_ESE_RD:
        begin
          is_rd    = 1'b1;
          rd_value = state_ff.ese;
        end
        sesr_pkg::CMD_ESR_RD:
        begin
          is_rd    = 1'b1;
          rd_value = std_q & sesr_pkg::STD_USED_MASK;
        end
        sesr_pkg::CMD_STB_RD:
        begin
          is_rd    = 1'b1;
          rd_value = stb_mss;
        end
        sesr_pkg::CMD_SRE_RD:
        begin
          is_rd    = 1'b1;
          rd_value = state_ff.sre;
        end
        sesr_pkg::CMD_OPE_RD:
        begin
          is_rd    = 1'b1;
          rd_value = state_ff.ope;
        end
        sesr_pkg::CMD_OPR_RD:
        begin
          is_rd    = 1'b1;
          rd_value = op_q;
        end
        sesr_pkg::CMD_OPCOND_RD:
        begin
          is_rd    = 1'b1;
          rd_value = i_op_cond;
        end
        sesr_pkg::CMD_SPOLL:
        begin
          is_rd    = 1'b1;
          rd_value = stb_poll;
        end
        default:
        begin
          is_rd    = 1'b0;
          rd_value = 8'h00;
        end
      endcase
    end
  end

  always_comb
  begin
    nxt_state           = state_ff;
    nxt_state.mss_prev  = mss;
    nxt_state.rsp.valid = is_rd;
    if (is_rd)
    begin
      nxt_state.rsp.value = rd_value;
      nxt_state.rsp.bcd   = to_bcd(rd_value);
    end
    if (cmd_v)
    begin
      case (i_cmd.code)
        sesr_pkg::CMD_ESE_WR:
          nxt_state.ese = i_cmd.data;
        sesr_pkg::CMD_SRE_WR:
          nxt_state.sre = i_cmd.data & sesr_pkg::SRE_WR_MASK;
        sesr_pkg::CMD_OPE_WR:
          nxt_state.ope = i_cmd.data;
        sesr_pkg::CMD_CLS:
          nxt_state.opc_arm = 1'b0;
        default:
          nxt_state.ope = state_ff.ope;
      endcase
    end
    if (opc_fire)
      nxt_state.opc_arm = 1'b0;
    if (cmd_v && (i_cmd.code == sesr_pkg::CMD_OPC))
      nxt_state.opc_arm = 1'b1;
    // a fresh rising edge beats a poll landing in the same cycle
    if (cmd_v && (i_cmd.code == sesr_pkg::CMD_SPOLL))
      nxt_state.rqs = 1'b0;
    if (mss_rise)
      nxt_state.rqs = 1'b1;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
    begin
      state_ff          <= '0;
      state_ff.ese      <= sesr_pkg::ENA_RESET;
      state_ff.ope      <= sesr_pkg::ENA_RESET;
      state_ff.sre      <= sesr_pkg::ENA_RESET;
    end
    else
      state_ff <= nxt_state;
  end

  assign o_rsp = state_ff.rsp;
  assign o_srq = state_ff.rqs;

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  logic q_esr;
  logic q_spoll;
  logic q_stb;
  assign q_esr   = cmd_v && (i_cmd.code == sesr_pkg::CMD_ESR_RD);
  assign q_spoll = cmd_v && (i_cmd.code == sesr_pkg::CMD_SPOLL);
  assign q_stb   = cmd_v && (i_cmd.code == sesr_pkg::CMD_STB_RD);

  cme_latch_a: assert property (
    i_std_evt.cmd_error |=> std_q[sesr_pkg::STD_CME]
      && (esb || !state_ff.ese[sesr_pkg::STD_CME]))
    else $error("command error not latched");

  exe_qye_a: assert property (
    (i_std_evt.exec_error && i_std_evt.query_lost)
      |=> std_q[sesr_pkg::STD_EXE] && std_q[sesr_pkg::STD_QYE])
    else $error("execution or query error not latched");

  opc_done_a: assert property (
    (cmd_v && i_cmd.code == sesr_pkg::CMD_OPC) ##1 i_ops_idle
      |=> std_q[sesr_pkg::STD_OPC])
    else $error("completion bit not set after arming");

  esr_read_a: assert property (
    (q_esr && std_set == 8'h00)
      |=> o_rsp.valid && o_rsp.value == ($past(std_q) & 8'hb5)
          && std_q == 8'h00)
    else $error("event read did not return and clear");

  cls_clear_a: assert property (
    (cmd_v && i_cmd.code == sesr_pkg::CMD_CLS && std_set == 8'h00
     && i_op_cond == 8'h00) |=> !esb && !osb)
    else $error("clear-status left a summary set");

  opcond_rd_a: assert property (
    (cmd_v && i_cmd.code == sesr_pkg::CMD_OPCOND_RD)
      |=> o_rsp.valid && o_rsp.value == $past(i_op_cond))
    else $error("condition read mismatch");

  stb_read_a: assert property (
    q_stb |=> o_rsp.valid && o_rsp.value[6] == $past(mss)
              && o_rsp.value[4] == $past(i_msg_avail)
              && o_rsp.value[3:0] == 4'h0
              && state_ff.rqs == $past(state_ff.rqs || mss_rise))
    else $error("status query wrong or disturbed request");

  srq_rise_a: assert property (
    (mss && !state_ff.mss_prev) |=> o_srq ##0 $rose(state_ff.mss_prev))
    else $error("rising summary did not raise request");

  poll_clear_a: assert property (
    (q_spoll && !mss_rise) |=> !o_srq && o_rsp.valid
                               && o_rsp.value[6] == $past(o_srq))
    else $error("serial poll did not return and clear request");

  no_rerequest_a: assert property (
    (!o_srq && state_ff.mss_prev && mss) |=> !o_srq)
    else $error("request repeated without a cleared source");

  bcd_form_a: assert property (
    is_rd |=> o_rsp.bcd[3:0] <= 4'h9 && o_rsp.bcd[7:4] <= 4'h9
              && o_rsp.bcd[11:8] <= 4'h2
              && (int'(o_rsp.bcd[11:8]) * 100 + int'(o_rsp.bcd[7:4]) * 10
                  + int'(o_rsp.bcd[3:0])) == int'(o_rsp.value))
    else $error("decimal digits out of range");

  sre_mask_a: assert property (
    (cmd_v && i_cmd.code == sesr_pkg::CMD_SRE_WR)
      |=> state_ff.sre == ($past(i_cmd.data) & 8'hbf))
    else $error("request mask write wrong");

  op_read_a: assert property (
    (cmd_v && i_cmd.code == sesr_pkg::CMD_OPR_RD && i_op_cond == 8'h00)
      |=> o_rsp.valid && o_rsp.value == $past(op_q) && op_q == 8'h00)
    else $error("operation event read did not return and clear");

  mss_sum_a: assert property (
    q_stb |=> o_rsp.value[6]
              == |(o_rsp.value & $past(state_ff.sre) & 8'hbf))
    else $error("master summary disagrees with enabled bits");

  srq_cause_a: assert property (
    (!o_srq ##1 o_srq) |-> $past(mss_rise))
    else $error("request line rose without a rising summary");

  srq_raised_c: cover property (mss_rise ##1 o_srq);
  poll_seen_c:  cover property (o_srq && q_spoll);
  esr_clear_c:  cover property (q_esr && std_q != 8'h00);
  opc_fire_c:   cover property (opc_fire);
  mss_hold_c:   cover property (q_spoll ##1 mss);

endmodule : sesr_status_core
`default_nettype wire

// *** common/sesr_pkg.sv ***
// shared constants and types of the status and service request block
package sesr_pkg;

  // standard event register bit positions
  localparam int unsigned STD_PON = 7;
  localparam int unsigned STD_CME = 5;
  localparam int unsigned STD_EXE = 4;
  localparam int unsigned STD_QYE = 2;
  localparam int unsigned STD_OPC = 0;

  // operation event register bit positions
  localparam int unsigned OP_COMM_FAIL   = 7;
  localparam int unsigned OP_CAL_BAD     = 6;
  localparam int unsigned OP_TUNE_IDLE   = 5;
  localparam int unsigned OP_FRESH       = 4;
  localparam int unsigned OP_RAMP_ONE    = 3;
  localparam int unsigned OP_RAMP_TWO    = 2;
  localparam int unsigned OP_OVERRANGE   = 1;
  localparam int unsigned OP_ALARM       = 0;

  // status byte bit positions
  localparam int unsigned SB_OSB = 7;
  localparam int unsigned SB_MSS = 6;
  localparam int unsigned SB_ESB = 5;
  localparam int unsigned SB_MAV = 4;

  // values after reset; power-up marks itself in the standard events
  localparam logic [7:0] STD_RESET = 8'h80;
  localparam logic [7:0] OP_RESET  = 8'h00;
  localparam logic [7:0] ENA_RESET = 8'h00;

  // implemented bits; bit 6 of the request mask has no summary behind it
  localparam logic [7:0] STD_USED_MASK = 8'hb5;
  localparam logic [7:0] SRE_WR_MASK   = 8'hbf;

  typedef enum logic [3:0] {
    CMD_NONE      = 4'h0,
    CMD_ESE_WR    = 4'h1,
    CMD_ESE_RD    = 4'h2,
    CMD_ESR_RD    = 4'h3,
    CMD_STB_RD    = 4'h4,
    CMD_SRE_WR    = 4'h5,
    CMD_SRE_RD    = 4'h6,
    CMD_OPC       = 4'h7,
    CMD_CLS       = 4'h8,
    CMD_OPE_WR    = 4'h9,
    CMD_OPE_RD    = 4'ha,
    CMD_OPR_RD    = 4'hb,
    CMD_OPCOND_RD = 4'hc,
    CMD_SPOLL     = 4'hd
  } sesr_cmd_e;

  typedef struct packed {
    logic      valid;
    sesr_cmd_e code;
    logic [7:0] data;
  } sesr_cmd_s;

  typedef struct packed {
    logic        valid;
    logic [7:0]  value;
    logic [11:0] bcd;
  } sesr_rsp_s;

  typedef struct packed {
    logic cmd_error;
    logic exec_error;
    logic query_lost;
  } sesr_std_evt_s;

  typedef struct packed {
    logic [7:0] bits;
  } sesr_evt_st_s;

  typedef struct packed {
    logic [7:0] ese;
    logic [7:0] ope;
    logic [7:0] sre;
    logic       opc_arm;
    logic       mss_prev;
    logic       rqs;
    sesr_rsp_s  rsp;
  } sesr_main_st_s;

endpackage : sesr_pkg

// *** hw/sesr_evt_reg.sv ***
// latched eight-bit event register with clear, set winning over clear
`timescale 1ns/1ps
`default_nettype none
module sesr_evt_reg #(
  parameter logic [7:0] RESET_VAL = 8'h00
) (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst_n,
  input  wire logic [7:0] i_set,
  input  wire logic       i_clear,
  output logic      [7:0] o_value
);

  sesr_pkg::sesr_evt_st_s state_ff;
  sesr_pkg::sesr_evt_st_s nxt_state;
  logic [7:0]             nxt_bits;

  // an event landing in the clearing cycle survives the clear
  genvar b;
  generate
    for (b = 0; b < 8; b++)
    begin : g_bit
      assign nxt_bits[b] = i_set[b] | (state_ff.bits[b] & ~i_clear);
    end
  endgenerate

  always_comb
  begin
    nxt_state      = state_ff;
    nxt_state.bits = nxt_bits;
  end

  always_ff @(posedge i_ref_clk)
  begin
    if (!i_rst_n)
      state_ff <= '{bits: RESET_VAL};
    else
      state_ff <= nxt_state;
  end

  assign o_value = state_ff.bits;

endmodule : sesr_evt_reg
`default_nettype wire

// *** dv/sesr_ctrl_model.sv ***
// bus controller model: sends one command at a time and takes the answer
`timescale 1ns/1ps
`default_nettype none
module sesr_ctrl_model (
  input  wire logic                i_ref_clk,
  input  wire sesr_pkg::sesr_rsp_s i_rsp,
  output var  sesr_pkg::sesr_cmd_s o_cmd
);
  initial o_cmd = '0;

  // a serial poll goes through here too; its answer carries the request bit
  task automatic issue(input  sesr_pkg::sesr_cmd_e c,
                       input  logic [7:0]          d,
                       output sesr_pkg::sesr_rsp_s r);
    @(posedge i_ref_clk);
    o_cmd <= '{valid: 1'b1, code: c, data: d};
    @(posedge i_ref_clk);
    o_cmd.valid <= 1'b0;
    // released data does not keep its last value
    o_cmd.data  <= ~d;
    // the answer stands one cycle and is taken at the edge that ends it
    @(posedge i_ref_clk);
    r = i_rsp;
  endtask : issue
endmodule : sesr_ctrl_model
`default_nettype wire

// *** dv/sesr_status_core_tb.sv ***
// self-checking bench of the status and service request block
`timescale 1ns/1ps
`default_nettype none
module sesr_status_core_tb;
  logic                    ref_clk;
  logic                    rst_n;
  sesr_pkg::sesr_cmd_s     cmd;
  sesr_pkg::sesr_std_evt_s std_evt;
  logic                    ops_idle;
  logic [7:0]              op_cond;
  logic                    mav;
  sesr_pkg::sesr_rsp_s     rsp;
  sesr_pkg::sesr_rsp_s     r_last;
  logic                    srq;
  int                      err_count;
  int                      checks;
  int                      cycles;

  sesr_status_core i_sesr_status_core (
    .i_ref_clk   (ref_clk),
    .i_rst_n     (rst_n),
    .i_cmd       (cmd),
    .i_std_evt   (std_evt),
    .i_ops_idle  (ops_idle),
    .i_op_cond   (op_cond),
    .i_msg_avail (mav),
    .o_rsp       (rsp),
    .o_srq       (srq)
  );

  sesr_ctrl_model i_sesr_ctrl_model (
    .i_ref_clk (ref_clk),
    .i_rsp     (rsp),
    .o_cmd     (cmd)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : tally_and_finish

  // a hang would otherwise stall the run with no verdict
  always @(posedge ref_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic q(input sesr_pkg::sesr_cmd_e c, input logic [7:0] e);
    i_sesr_ctrl_model.issue(c, 8'h00, r_last);
    chk({3'h0, r_last.valid, r_last.value}, {4'h1, e});
  endtask : q

  task automatic w(input sesr_pkg::sesr_cmd_e c, input logic [7:0] d);
    sesr_pkg::sesr_rsp_s r;
    i_sesr_ctrl_model.issue(c, d, r);
  endtask : w

  // events latch at the edge after they rise; the line follows one edge later
  task automatic pulse(input logic [2:0] e, input logic [7:0] op,
                       input logic s);
    @(posedge ref_clk);
    std_evt <= e;
    op_cond <= op;
    @(posedge ref_clk);
    std_evt <= '0;
    op_cond <= 8'h00;
    @(posedge ref_clk);
    #1;
    chk({11'h0, srq}, {11'h0, s});
  endtask : pulse

  task automatic done(input string s);
    $display("test %s done", s);
  endtask : done

  initial
  begin
    rst_n     = 1'b0;
    std_evt   = '0;
    ops_idle  = 1'b0;
    op_cond   = 8'h00;
    mav       = 1'b0;
    err_count = 0;
    checks    = 0;
    cycles    = 0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    q(sesr_pkg::CMD_ESR_RD, 8'h80);
    chk(r_last.bcd, 12'h128);
    q(sesr_pkg::CMD_ESR_RD, 8'h00);
    pulse(3'b111, 8'h00, 1'b0);
    q(sesr_pkg::CMD_ESR_RD, 8'h34);
    chk(r_last.bcd, 12'h052);
    done("power_and_errors");
    w(sesr_pkg::CMD_OPC, 8'h00);
    q(sesr_pkg::CMD_ESR_RD, 8'h00);
    @(posedge ref_clk);
    ops_idle <= 1'b1;
    q(sesr_pkg::CMD_ESR_RD, 8'h01);
    // arming while already idle completes in the cycle after the command
    w(sesr_pkg::CMD_OPC, 8'h00);
    q(sesr_pkg::CMD_ESR_RD, 8'h01);
    done("completion");
    for (int i = 0; i < 8; i++)
    begin
      pulse(3'b000, 8'h01 << i, 1'b0);
      q(sesr_pkg::CMD_OPR_RD, 8'h01 << i);
    end
    @(posedge ref_clk);
    op_cond <= 8'h81;
    q(sesr_pkg::CMD_OPCOND_RD, 8'h81);
    @(posedge ref_clk);
    op_cond <= 8'h00;
    q(sesr_pkg::CMD_OPR_RD, 8'h81);
    w(sesr_pkg::CMD_OPE_WR, 8'h04);
    q(sesr_pkg::CMD_OPE_RD, 8'h04);
    done("operation_events");
    w(sesr_pkg::CMD_ESE_WR, 8'h20);
    q(sesr_pkg::CMD_ESE_RD, 8'h20);
    w(sesr_pkg::CMD_SRE_WR, 8'hff);
    q(sesr_pkg::CMD_SRE_RD, 8'hbf);
    pulse(3'b100, 8'h00, 1'b1);
    q(sesr_pkg::CMD_STB_RD, 8'h60);
    q(sesr_pkg::CMD_SPOLL, 8'h60);
    chk({11'h0, srq}, 12'h000);
    q(sesr_pkg::CMD_STB_RD, 8'h60);
    pulse(3'b100, 8'h00, 1'b0);
    q(sesr_pkg::CMD_ESR_RD, 8'h20);
    q(sesr_pkg::CMD_STB_RD, 8'h00);
    done("service_request");
    pulse(3'b000, 8'h04, 1'b1);
    q(sesr_pkg::CMD_STB_RD, 8'hc0);
    q(sesr_pkg::CMD_SPOLL, 8'hc0);
    @(posedge ref_clk);
    mav <= 1'b1;
    q(sesr_pkg::CMD_STB_RD, 8'hd0);
    chk(r_last.bcd, 12'h208);
    pulse(3'b110, 8'h00, 1'b0);
    w(sesr_pkg::CMD_CLS, 8'h00);
    q(sesr_pkg::CMD_STB_RD, 8'h50);
    q(sesr_pkg::CMD_ESR_RD, 8'h00);
    w(sesr_pkg::CMD_SRE_WR, 8'h00);
    q(sesr_pkg::CMD_STB_RD, 8'h10);
    @(posedge ref_clk);
    mav <= 1'b0;
    q(sesr_pkg::CMD_STB_RD, 8'h00);
    done("summary_and_clear");
    // a power cycle in mid-run drops the request and marks power-up again
    w(sesr_pkg::CMD_SRE_WR, 8'h20);
    pulse(3'b100, 8'h00, 1'b1);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    chk({11'h0, srq}, 12'h000);
    q(sesr_pkg::CMD_ESR_RD, 8'h80);
    q(sesr_pkg::CMD_SRE_RD, 8'h00);
    q(sesr_pkg::CMD_ESE_RD, 8'h00);
    done("power_cycle");
    tally_and_finish();
  end
endmodule : sesr_status_core_tb
`default_nettype wire
